//--- hw/adcc_pkg.sv
// Notes on behaviour
// - a start write converts the selected channel and loads the 8-bit result
// - writing zero to start does nothing; start reads back as zero
// - conversion ends at result load; result split into low and high nibbles
// - the done flag is set in the same cycle as the result register is written
// - the done flag is set whatever the mask holds
// - interrupt request only while flag and mask are both one
// - writing one clears the flag, zero leaves it; read shows the flag
// - the completion interrupt uses a fixed vector address
// - each pin enable bit turns its port pin into an analog input
// - clock source bit picks fast oscillator when one, slow when zero
// - channel field codes 0 to 3 pick analog inputs 0 to 3
// - supply select bit picks booster output when one, main supply when zero
// - all control bits, mask and flag reset to zero; result undefined
// - unused bits of control, mask and flag registers read as zero
// - the start write also makes the clock selector forward the clock
// - after a delay the input is sampled, then resolved bit by bit
package adcc_pkg;
    localparam logic [15:0] ADDR_SUPPLY   = 16'hFF01;
    localparam logic [15:0] ADDR_CONTROL  = 16'hFFD0;
    localparam logic [15:0] ADDR_PIN_EN   = 16'hFFD1;
    localparam logic [15:0] ADDR_RES_LO   = 16'hFFD2;
    localparam logic [15:0] ADDR_RES_HI   = 16'hFFD3;
    localparam logic [15:0] ADDR_MASK     = 16'hFFE7;
    localparam logic [15:0] ADDR_FLAG     = 16'hFFF7;
    localparam logic [15:0] IRQ_VECTOR    = 16'h010E;
    // field positions
    localparam int          BIT_START     = 3;
    localparam int          BIT_CLK_SRC   = 2;
    localparam int          BIT_CHAN_LO   = 0;
    localparam int          BIT_SUPPLY    = 3;
    localparam int          BIT_OSC_REG   = 2;
    localparam int          BIT_MASK      = 0;
    localparam int          BIT_FLAG      = 0;
    // reset values
    localparam logic [3:0]  RST_NIBBLE    = 4'h0;
    localparam logic [7:0]  RST_RESULT    = 8'h00;
    // timing: sample delay and sample length in converter clock periods
    localparam int          SAMPLE_DELAY  = 2;
    localparam int          SAMPLE_LEN    = 2;
    localparam int          RES_BITS      = 8;
    // slow and fast converter clock rates from the system clock
    localparam int          SYS_HZ        = 125000000;
    localparam int          SLOW_HZ       = 32768;
    localparam int          FAST_HZ       = 1000000;
    localparam int          SLOW_DIV      = SYS_HZ / SLOW_HZ;
    localparam int          FAST_DIV      = SYS_HZ / FAST_HZ;
endpackage : adcc_pkg

//--- hw/adcc_clk_sel.sv
`timescale 1ns/1ps
// clock selector: enable pulses at slow or fast converter rate while running
module adcc_clk_sel #(
    parameter int SLOW_DIV = adcc_pkg::SLOW_DIV,
    parameter int FAST_DIV = adcc_pkg::FAST_DIV
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // control
    input  wire logic run,
    input  wire logic fastSel,
    // output
    output logic      convTick
);
    localparam int CW = $clog2(SLOW_DIV + 1);
    logic [CW-1:0] divCnt_r;
    logic [CW-1:0] divTop;

    initial begin
        // a tick must outlast the trial register and the comparator synchroniser
        if (FAST_DIV < 4 || FAST_DIV > SLOW_DIV) begin
            $error("adcc_clk_sel: bad divider values");
        end
    end

    assign divTop = fastSel ? CW'(FAST_DIV - 1) : CW'(SLOW_DIV - 1);

    always_ff @(posedge clk_sys) begin
        if (rst || !run) begin
            divCnt_r <= '0;
            convTick <= 1'b0;
        end else if (divCnt_r >= divTop) begin
            divCnt_r <= '0;
            convTick <= 1'b1;
        end else begin
            divCnt_r <= divCnt_r + CW'(1);
            convTick <= 1'b0;
        end
    end
endmodule : adcc_clk_sel

//--- hw/adcc_sar.sv
`timescale 1ns/1ps
// successive-approximation sequencer driving the sample-hold core
module adcc_sar #(
    parameter int NBITS = adcc_pkg::RES_BITS
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // control
    input  wire logic             go,
    input  wire logic             tick,
    // analog core
    input  wire logic             cmpHigh,
    output logic                  sampleOn,
    output logic [NBITS-1:0]      trialCode,
    // result
    output logic                  doneP,
    output logic [NBITS-1:0]      result
);
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_SAMP, S_CONV} adcc_sar_e;
    adcc_sar_e        state_r;
    logic [3:0]       cnt_r;
    logic [NBITS-1:0] bitPtr_r;

    initial begin
        if (NBITS < 2 || NBITS > 16) begin
            $error("adcc_sar: NBITS out of range");
        end
    end

    // delay, sample, then resolve bit by bit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r   <= S_IDLE;
            cnt_r     <= '0;
            bitPtr_r  <= '0;
            trialCode <= '0;
            sampleOn  <= 1'b0;
            doneP     <= 1'b0;
            result    <= '0;
        end else begin
            doneP <= 1'b0;
            unique case (state_r)
                S_IDLE: begin
                    if (go) begin
                        state_r <= S_WAIT;
                        cnt_r   <= 4'(adcc_pkg::SAMPLE_DELAY - 1);
                    end
                end
                S_WAIT: begin
                    if (tick) begin
                        if (cnt_r == '0) begin
                            state_r  <= S_SAMP;
                            sampleOn <= 1'b1;
                            cnt_r    <= 4'(adcc_pkg::SAMPLE_LEN - 1);
                        end else begin
                            cnt_r <= cnt_r - 4'h1;
                        end
                    end
                end
                S_SAMP: begin
                    if (tick) begin
                        if (cnt_r == '0) begin
                            state_r   <= S_CONV;
                            sampleOn  <= 1'b0;
                            bitPtr_r  <= {1'b1, {(NBITS-1){1'b0}}};
                            trialCode <= {1'b1, {(NBITS-1){1'b0}}};
                        end else begin
                            cnt_r <= cnt_r - 4'h1;
                        end
                    end
                end
                S_CONV: begin
                    if (tick) begin
                        if (bitPtr_r[0]) begin
                            result  <= cmpHigh ? trialCode : (trialCode & ~bitPtr_r);
                            doneP   <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            trialCode <= (cmpHigh ? trialCode : (trialCode & ~bitPtr_r))
                                         | (bitPtr_r >> 1);
                            bitPtr_r  <= bitPtr_r >> 1;
                        end
                    end
                end
            endcase
        end
    end
endmodule : adcc_sar

//--- hw/adcc_top.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// converter control: registers, clock selector, sequencer and done interrupt
module adcc_top #(
    parameter int SLOW_DIV = adcc_pkg::SLOW_DIV,
    parameter int FAST_DIV = adcc_pkg::FAST_DIV
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // register port
    input  wire logic [15:0] regAddr,
    input  wire logic [3:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [3:0]  regRdata,
    // analog core
    input  wire logic        cmpHighPin,
    output logic      [3:0]  analogPinEn,
    output logic      [1:0]  chanSel,
    output logic             convSupplySel,
    output logic             oscRegulatorSupplySel,
    output logic             convClkSrc,
    output logic             sampleOn,
    output logic      [7:0]  trialCode,
    // interrupt and status
    output logic             irqReq,
    output logic      [15:0] irqVector,
    output logic             busy
);
    logic       cmpMeta_r;
    logic       cmpSync_r;
    logic       convTick;
    logic       sarDone;
    logic [7:0] sarResult;
    logic       sarSample;
    logic [7:0] sarTrial;
    logic       doneFlag_r;
    logic       doneMask_r;
    logic [7:0] result_r;
    logic       startOk;

    // comparator from the analog side: two-stage synchroniser
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmpMeta_r <= 1'b0;
            cmpSync_r <= 1'b0;
        end else begin
            cmpMeta_r <= cmpHighPin;
            cmpSync_r <= cmpMeta_r;
        end
    end

    // start only on a one written while idle
    assign startOk = regWr && regAddr == adcc_pkg::ADDR_CONTROL
                     && regWdata[adcc_pkg::BIT_START] && !busy;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            analogPinEn           <= adcc_pkg::RST_NIBBLE;
            chanSel               <= 2'h0;
            convClkSrc            <= 1'b0;
            convSupplySel         <= 1'b0;
            oscRegulatorSupplySel <= 1'b0;
            doneMask_r            <= 1'b0;
        end else if (regWr) begin
            unique case (regAddr)
                adcc_pkg::ADDR_CONTROL: begin
                    convClkSrc <= regWdata[adcc_pkg::BIT_CLK_SRC];
                    chanSel    <= regWdata[adcc_pkg::BIT_CHAN_LO +: 2];
                end
                adcc_pkg::ADDR_PIN_EN: analogPinEn <= regWdata;
                adcc_pkg::ADDR_SUPPLY: begin
                    convSupplySel         <= regWdata[adcc_pkg::BIT_SUPPLY];
                    oscRegulatorSupplySel <= regWdata[adcc_pkg::BIT_OSC_REG];
                end
                adcc_pkg::ADDR_MASK: doneMask_r <= regWdata[adcc_pkg::BIT_MASK];
                default: ;
            endcase
        end
    end

    // busy from start write until result load
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (startOk) begin
            busy <= 1'b1;
        end else if (sarDone) begin
            busy <= 1'b0;
        end
    end

    // clock selector forwards the clock while busy
    adcc_clk_sel #(
        .SLOW_DIV (SLOW_DIV),
        .FAST_DIV (FAST_DIV)
    ) u_clk_sel (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .run      (busy),
        .fastSel  (convClkSrc),
        .convTick (convTick)
    );

    adcc_sar #(
        .NBITS (adcc_pkg::RES_BITS)
    ) u_sar (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .go        (startOk),
        .tick      (convTick),
        .cmpHigh   (cmpSync_r),
        .sampleOn  (sarSample),
        .trialCode (sarTrial),
        .doneP     (sarDone),
        .result    (sarResult)
    );

    // analog core outputs registered
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sampleOn  <= 1'b0;
            trialCode <= 8'h00;
        end else begin
            sampleOn  <= sarSample;
            trialCode <= sarTrial;
        end
    end

    // result register, zero after reset though undefined by contract
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result_r <= adcc_pkg::RST_RESULT;
        end else if (sarDone) begin
            result_r <= sarResult;
        end
    end

    // flag set on load; set wins over write-one clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            doneFlag_r <= 1'b0;
        end else if (sarDone) begin
            doneFlag_r <= 1'b1;
        end else if (regWr && regAddr == adcc_pkg::ADDR_FLAG
                     && regWdata[adcc_pkg::BIT_FLAG]) begin
            doneFlag_r <= 1'b0;
        end
    end

    // request gated by mask, fixed vector
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqReq    <= 1'b0;
            irqVector <= adcc_pkg::IRQ_VECTOR;
        end else begin
            irqReq    <= doneFlag_r && doneMask_r;
            irqVector <= adcc_pkg::IRQ_VECTOR;
        end
    end

    // read mux; start bit and unused bits read zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdata <= 4'h0;
        end else if (regRd) begin
            unique case (regAddr)
                adcc_pkg::ADDR_CONTROL: regRdata <= {1'b0, convClkSrc, chanSel};
                adcc_pkg::ADDR_PIN_EN:  regRdata <= analogPinEn;
                adcc_pkg::ADDR_SUPPLY:  regRdata <= {convSupplySel, oscRegulatorSupplySel, 2'b00};
                adcc_pkg::ADDR_RES_LO:  regRdata <= result_r[3:0];
                adcc_pkg::ADDR_RES_HI:  regRdata <= result_r[7:4];
                adcc_pkg::ADDR_MASK:    regRdata <= {3'b000, doneMask_r};
                adcc_pkg::ADDR_FLAG:    regRdata <= {3'b000, doneFlag_r};
                default:                regRdata <= 4'h0;
            endcase
        end else begin
            regRdata <= 4'h0;
        end
    end
endmodule : adcc_top

//--- dv/adcc_properties.sv
`timescale 1ns/1ps
// port-level checks of the converter control block
module adcc_properties #(
    parameter int SLOW_DIV = 4,
    parameter int FAST_DIV = 2
) (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [3:0]  regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [3:0]  regRdata,
    // converter and status
    input wire logic [3:0]  analogPinEn,
    input wire logic [1:0]  chanSel,
    input wire logic        sampleOn,
    input wire logic        irqReq,
    input wire logic [15:0] irqVector,
    input wire logic        busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // start write accepted while idle
    sequence s_start;
        regWr && regAddr == adcc_pkg::ADDR_CONTROL && regWdata[3] && !busy;
    endsequence
    // conversion runs then ends
    sequence s_run;
        busy ##[1:1000] !busy;
    endsequence
    property p_start_busy;
        s_start |=> busy [*8];
    endproperty
    property p_busy_end;
        s_start |=> s_run;
    endproperty
    property p_no_start;
        regWr && regAddr == adcc_pkg::ADDR_CONTROL && !regWdata[3] && !busy |=> !busy;
    endproperty
    property p_rdata_idle;
        !$past(regRd) |-> regRdata == 4'h0;
    endproperty
    property p_pin_en;
        regWr && regAddr == adcc_pkg::ADDR_PIN_EN |=> analogPinEn == $past(regWdata);
    endproperty
    property p_pin_rd;
        regRd && regAddr == adcc_pkg::ADDR_PIN_EN |=> regRdata == analogPinEn;
    endproperty
    property p_chan;
        regWr && regAddr == adcc_pkg::ADDR_CONTROL && !busy |=> chanSel == $past(regWdata[1:0]);
    endproperty
    property p_mask_off;
        regWr && regAddr == adcc_pkg::ADDR_MASK && !regWdata[0] |-> ##2 !irqReq;
    endproperty
    property p_clear;
        regWr && regAddr == adcc_pkg::ADDR_FLAG && regWdata[0] && !busy && !$past(busy)
            |-> ##2 !irqReq;
    endproperty
    property p_sample_busy;
        $rose(sampleOn) |-> busy;
    endproperty
    property p_vector;
        irqVector == adcc_pkg::IRQ_VECTOR;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start did not hold busy");
    a_busy_end: assert property (p_busy_end) else $error("conversion never ended");
    a_no_start: assert property (p_no_start) else $error("zero start began work");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    a_pin_en: assert property (p_pin_en) else $error("pin enable not written");
    a_pin_rd: assert property (p_pin_rd) else $error("pin enable read wrong");
    a_chan: assert property (p_chan) else $error("channel field not written");
    a_mask_off: assert property (p_mask_off) else $error("masked request seen");
    a_clear: assert property (p_clear) else $error("flag clear left request");
    a_sample_busy: assert property (p_sample_busy) else $error("sampling while idle");
    a_vector: assert property (p_vector) else $error("vector wrong");
endmodule : adcc_properties

//--- dv/adcc_analog_model.sv
`timescale 1ns/1ps
// analog multiplexer, sample-hold and comparator
module adcc_analog_model (
    // clock
    input  wire logic        clk_sys,
    // converter side
    input  wire logic [31:0] vinAll,
    input  wire logic [3:0]  analogPinEn,
    input  wire logic [1:0]  chanSel,
    input  wire logic        sampleOn,
    input  wire logic [7:0]  trialCode,
    output logic             cmpHigh
);
    logic [7:0] held = 8'h00;
    logic       junk = 1'b0;
    always_ff @(posedge clk_sys) begin
        junk <= !junk;
        if (sampleOn) held <= vinAll[chanSel*8 +: 8];
    end
    assign cmpHigh = analogPinEn[chanSel] ? (held >= trialCode) : junk;
endmodule : adcc_analog_model

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int SDIV = 8;
    localparam int FDIV = 4;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] regAddr = 16'h0000;
    logic [3:0]  regWdata = 4'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [3:0]  regRdata, analogPinEn, v, lo;
    logic [1:0]  chanSel;
    logic [7:0]  trialCode;
    logic [15:0] irqVector;
    logic        cmpHigh, convSupplySel, convClkSrc, sampleOn, irqReq, busy, oscRegSel;
    logic [31:0] vinAll = 32'hFF00_5AA5;
    int          error_cnt = 0;
    int          comparisons = 0;
    // design and far side
    adcc_top #(.SLOW_DIV(SDIV), .FAST_DIV(FDIV)) uut (.clk_sys(clk_sys), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .cmpHighPin(cmpHigh), .analogPinEn(analogPinEn),
        .chanSel(chanSel), .convSupplySel(convSupplySel), .oscRegulatorSupplySel(oscRegSel),
        .convClkSrc(convClkSrc), .sampleOn(sampleOn), .trialCode(trialCode),
        .irqReq(irqReq), .irqVector(irqVector), .busy(busy));
    adcc_analog_model partner (.clk_sys(clk_sys), .vinAll(vinAll),
        .analogPinEn(analogPinEn), .chanSel(chanSel), .sampleOn(sampleOn),
        .trialCode(trialCode), .cmpHigh(cmpHigh));
    // compare and count
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one-cycle register write
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    // one-cycle register read, data taken in the following cycle
    task automatic rd(input logic [15:0] a, output logic [3:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdata;
        @(posedge clk_sys);
    endtask : rd
    task automatic end_sim();
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // reset values and unmapped address
    task automatic t_reset();
        logic [15:0] al [6] = '{adcc_pkg::ADDR_SUPPLY, adcc_pkg::ADDR_CONTROL,
            adcc_pkg::ADDR_PIN_EN, adcc_pkg::ADDR_MASK, adcc_pkg::ADDR_FLAG, 16'hFFD4};
        foreach (al[i]) begin
            rd(al[i], v);
            chk("resetReg", v, 4'h0);
        end
        chk("pinEn", analogPinEn, 4'h0);
        chk("oscRegSel", oscRegSel, 1'b0);
        chk("vector", irqVector, adcc_pkg::IRQ_VECTOR);
    endtask : t_reset
    // control registers, unused bits and read-back
    task automatic t_regs();
        wr(adcc_pkg::ADDR_SUPPLY, 4'hF);
        rd(adcc_pkg::ADDR_SUPPLY, v);
        chk("supply", v, 4'hC);
        chk("supplySel", convSupplySel, 1'b1);
        chk("oscRegSel", oscRegSel, 1'b1);
        wr(adcc_pkg::ADDR_SUPPLY, 4'h0);
        wr(adcc_pkg::ADDR_MASK, 4'hF);
        rd(adcc_pkg::ADDR_MASK, v);
        chk("mask", v, 4'h1);
        wr(adcc_pkg::ADDR_MASK, 4'h0);
        wr(adcc_pkg::ADDR_PIN_EN, 4'hF);
        rd(adcc_pkg::ADDR_PIN_EN, v);
        chk("pinEn", v, 4'hF);
        wr(adcc_pkg::ADDR_CONTROL, 4'h7);
        rd(adcc_pkg::ADDR_CONTROL, v);
        chk("control", v, 4'h7);
        chk("busy", busy, 1'b0);
    endtask : t_regs
    // one conversion with a late second start, then the done interrupt
    task automatic t_conv(input logic [1:0] ch);
        int div;
        int n;
        int tc;
        div = ch[0] ? FDIV : SDIV;
        wr(adcc_pkg::ADDR_CONTROL, {1'b0, ch[0], ch});
        wr(adcc_pkg::ADDR_CONTROL, {1'b1, ch[0], ch});
        chk("busy", busy, 1'b1);
        chk("clkSrc", convClkSrc, ch[0]);
        chk("chanSel", chanSel, ch);
        repeat (6 * div) @(posedge clk_sys);
        wr(adcc_pkg::ADDR_CONTROL, {1'b1, ch[0], ch});
        n = 6 * div + 4;
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        tc = (adcc_pkg::SAMPLE_DELAY + adcc_pkg::SAMPLE_LEN + adcc_pkg::RES_BITS) * div;
        chk("convShort", n >= tc && n <= tc + 8, 1'b1);
        repeat (2) @(posedge clk_sys);
        rd(adcc_pkg::ADDR_RES_LO, lo);
        rd(adcc_pkg::ADDR_RES_HI, v);
        chk("result", {v, lo}, vinAll[ch*8 +: 8]);
        rd(adcc_pkg::ADDR_FLAG, v);
        chk("flagSet", v, 4'h1);
        chk("irqMasked", irqReq, 1'b0);
        wr(adcc_pkg::ADDR_FLAG, 4'h0);
        rd(adcc_pkg::ADDR_FLAG, v);
        chk("flagKept", v, 4'h1);
        wr(adcc_pkg::ADDR_MASK, 4'h1);
        repeat (2) @(posedge clk_sys);
        chk("irqOn", irqReq, 1'b1);
        wr(adcc_pkg::ADDR_MASK, 4'h0);
        repeat (2) @(posedge clk_sys);
        chk("irqMaskOff", irqReq, 1'b0);
        wr(adcc_pkg::ADDR_MASK, 4'h1);
        repeat (2) @(posedge clk_sys);
        chk("irqBack", irqReq, 1'b1);
        wr(adcc_pkg::ADDR_FLAG, 4'h1);
        repeat (2) @(posedge clk_sys);
        chk("irqOff", irqReq, 1'b0);
        rd(adcc_pkg::ADDR_FLAG, v);
        chk("flagClr", v, 4'h0);
        wr(adcc_pkg::ADDR_MASK, 4'h0);
    endtask : t_conv
    initial forever #4 clk_sys = ~clk_sys;
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_regs();
        for (int c = 0; c < 4; c++) t_conv(c[1:0]);
        end_sim();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end
endmodule : testbench
bind adcc_top adcc_properties #(.SLOW_DIV(SLOW_DIV), .FAST_DIV(FAST_DIV)) chk (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .analogPinEn(analogPinEn), .chanSel(chanSel),
    .sampleOn(sampleOn), .irqReq(irqReq), .irqVector(irqVector), .busy(busy));
